// >>> logic/scan_sampling_sequencer.sv
`timescale 1ns/10ps
`default_nettype none

module scan_sampling_sequencer #(
  parameter int EXT_FULL_SCALE_MV = 2000
) (
  input  wire logic                                   ref_clk_i,
  input  wire logic                                   reset_n_i,
  input  wire logic [scan_sampling_pkg::ADDR_W-1:0]   reg_addr_i,
  input  wire logic [scan_sampling_pkg::DATA_W-1:0]   reg_wdata_i,
  input  wire logic                                   reg_wr_i,
  input  wire logic                                   reg_rd_i,
  output logic      [scan_sampling_pkg::DATA_W-1:0]   reg_rdata_o,
  input  wire scan_sampling_pkg::timing_pins_t        timing_pins_i,
  input  wire scan_sampling_pkg::rgb_t                signal_in_i,
  input  wire scan_sampling_pkg::rgb_t                reference_in_i,
  output logic      [scan_sampling_pkg::SAMPLE_W-1:0] conv_data_o,
  output logic                                        conv_valid_o,
  output logic      [1:0]                             conv_channel_o,
  output logic      [2:0]                             channel_enable_o,
  output logic                                        clamp_active_o,
  output logic      [11:0]                            clamp_level_mv_o
);

  localparam int SW = scan_sampling_pkg::SAMPLE_W;

  function automatic logic [SW-1:0] pick(input scan_sampling_pkg::rgb_t v,
                                         input logic [1:0] ch);
    logic [SW-1:0] r;
    r = v.red;
    if (ch == scan_sampling_pkg::CH_GREEN) begin
      r = v.green;
    end else if (ch == scan_sampling_pkg::CH_BLUE) begin
      r = v.blue;
    end
    return r;
  endfunction

  // Difference clipped at zero so a reversed pair cannot wrap to full scale.
  function automatic logic [SW-1:0] clip_diff(input logic [SW-1:0] a,
                                              input logic [SW-1:0] b);
    return (a > b) ? SW'(a - b) : '0;
  endfunction

  function automatic logic [SW-1:0] process_level(input logic [SW-1:0] level,
                                                  input logic [7:0] offset,
                                                  input logic [4:0] gain,
                                                  input int full_scale_mv);
    int off_mv;
    int off_lsb;
    int sum;
    int scaled;
    off_mv  = scan_sampling_pkg::OFFSET_MIN_MV
            + (int'(offset) * scan_sampling_pkg::OFFSET_SPAN_MV)
              / scan_sampling_pkg::OFFSET_CODES;
    off_lsb = (off_mv * scan_sampling_pkg::SAMPLE_CODES) / full_scale_mv;
    sum     = int'(level) + off_lsb;
    if (sum < 0) begin
      sum = 0;
    end
    scaled  = (sum * scan_sampling_pkg::GAIN_NUM)
            / (scan_sampling_pkg::GAIN_NUM - int'(gain));
    if (scaled > scan_sampling_pkg::SAMPLE_MAX) begin
      scaled = scan_sampling_pkg::SAMPLE_MAX;
    end
    return SW'(scaled);
  endfunction

  function automatic logic [1:0] first_channel(input logic bgr_order);
    return bgr_order ? scan_sampling_pkg::CH_BLUE : scan_sampling_pkg::CH_RED;
  endfunction

  function automatic logic [1:0] next_channel(input logic [1:0] ch,
                                              input logic bgr_order);
    logic [1:0] n;
    n = scan_sampling_pkg::CH_GREEN;
    if (ch == scan_sampling_pkg::CH_GREEN) begin
      n = bgr_order ? scan_sampling_pkg::CH_RED : scan_sampling_pkg::CH_BLUE;
    end else if (ch == scan_sampling_pkg::CH_BLUE && !bgr_order) begin
      n = scan_sampling_pkg::CH_RED;
    end else if (ch == scan_sampling_pkg::CH_RED && bgr_order) begin
      n = scan_sampling_pkg::CH_BLUE;
    end
    return n;
  endfunction

  // The reserved select code would index past the three channel settings, so it
  // falls back to red and a misprogrammed part still produces defined words.
  function automatic logic [1:0] safe_channel(input logic [1:0] ch);
    logic [1:0] s;
    s = ch;
    if (ch == scan_sampling_pkg::CH_RSVD) begin
      s = scan_sampling_pkg::CH_RED;
    end
    return s;
  endfunction

  logic [scan_sampling_pkg::CFG_W-1:0]    config_reg;
  logic [scan_sampling_pkg::OFFSET_W-1:0] offset_reg [3];
  logic [scan_sampling_pkg::GAIN_W-1:0]   gain_reg [3];

  scan_sampling_pkg::timing_pins_t pins_meta;
  scan_sampling_pkg::timing_pins_t pins_sync;
  scan_sampling_pkg::timing_pins_t pins_prev;
  scan_sampling_pkg::rgb_t         signal_meta;
  scan_sampling_pkg::rgb_t         signal_sync;
  scan_sampling_pkg::rgb_t         reference_meta;
  scan_sampling_pkg::rgb_t         reference_sync;

  scan_sampling_pkg::rgb_t         held_reference;
  scan_sampling_pkg::rgb_t         held_level;
  scan_sampling_pkg::seq_state_t   seq_state;
  logic [1:0]                      mux_channel;

  logic cis_mode;
  logic one_channel;
  logic bgr_order;
  logic [1:0] selected_channel;
  logic ref_fall;
  logic pix_fall;
  logic conv_rise;
  logic strobe_fall;
  logic converting;
  int   full_scale_mv;

  assign cis_mode         = config_reg[scan_sampling_pkg::SENSOR_TYPE_BIT];
  assign one_channel      = config_reg[scan_sampling_pkg::CHANNEL_COUNT_BIT];
  assign bgr_order        = config_reg[scan_sampling_pkg::MUX_ORDER_BIT];
  assign selected_channel = {config_reg[scan_sampling_pkg::CHANNEL_SELECT_HIGH],
                             config_reg[scan_sampling_pkg::CHANNEL_SELECT_LOW]};
  assign full_scale_mv    = config_reg[scan_sampling_pkg::EXT_REF_BIT] ? EXT_FULL_SCALE_MV :
                            config_reg[scan_sampling_pkg::REF_SELECT_BIT] ?
                            scan_sampling_pkg::FULL_SCALE_1V5_MV :
                            scan_sampling_pkg::FULL_SCALE_1V0_MV;

  // Pins are asynchronous to ref_clk_i; edges are found only after two stages.
  // The level words take the same two stages, so a word that moves at a sample edge may tear.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pins_meta      <= '0;
      pins_sync      <= '0;
      pins_prev      <= '0;
      signal_meta    <= '0;
      signal_sync    <= '0;
      reference_meta <= '0;
      reference_sync <= '0;
    end else begin
      pins_meta      <= timing_pins_i;
      pins_sync      <= pins_meta;
      pins_prev      <= pins_sync;
      signal_meta    <= signal_in_i;
      signal_sync    <= signal_meta;
      reference_meta <= reference_in_i;
      reference_sync <= reference_meta;
    end
  end

  assign ref_fall    = pins_prev.reference_sample_clock & ~pins_sync.reference_sample_clock;
  assign pix_fall    = pins_prev.pixel_sample_clock & ~pins_sync.pixel_sample_clock;
  assign conv_rise   = ~pins_prev.converter_clock & pins_sync.converter_clock;
  assign strobe_fall = pins_prev.line_start_strobe & ~pins_sync.line_start_strobe;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      config_reg <= scan_sampling_pkg::CONFIG_RESET;
      for (int i = 0; i < 3; i++) begin
        offset_reg[i] <= scan_sampling_pkg::OFFSET_RESET;
        gain_reg[i]   <= scan_sampling_pkg::GAIN_RESET;
      end
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        scan_sampling_pkg::ADDR_CONFIG:       config_reg    <= reg_wdata_i[6:0];
        scan_sampling_pkg::ADDR_RED_OFFSET:   offset_reg[0] <= reg_wdata_i;
        scan_sampling_pkg::ADDR_GREEN_OFFSET: offset_reg[1] <= reg_wdata_i;
        scan_sampling_pkg::ADDR_BLUE_OFFSET:  offset_reg[2] <= reg_wdata_i;
        scan_sampling_pkg::ADDR_RED_GAIN:     gain_reg[0]   <= reg_wdata_i[4:0];
        scan_sampling_pkg::ADDR_GREEN_GAIN:   gain_reg[1]   <= reg_wdata_i[4:0];
        scan_sampling_pkg::ADDR_BLUE_GAIN:    gain_reg[2]   <= reg_wdata_i[4:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        scan_sampling_pkg::ADDR_CONFIG:       reg_rdata_o <= {1'b0, config_reg};
        scan_sampling_pkg::ADDR_RED_OFFSET:   reg_rdata_o <= offset_reg[0];
        scan_sampling_pkg::ADDR_GREEN_OFFSET: reg_rdata_o <= offset_reg[1];
        scan_sampling_pkg::ADDR_BLUE_OFFSET:  reg_rdata_o <= offset_reg[2];
        scan_sampling_pkg::ADDR_RED_GAIN:     reg_rdata_o <= {3'h0, gain_reg[0]};
        scan_sampling_pkg::ADDR_GREEN_GAIN:   reg_rdata_o <= {3'h0, gain_reg[1]};
        scan_sampling_pkg::ADDR_BLUE_GAIN:    reg_rdata_o <= {3'h0, gain_reg[2]};
        default:                              reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // All three samplers run in every mode; the mux alone decides what converts.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      held_reference <= '0;
      held_level     <= '0;
    end else begin
      if (ref_fall) begin
        if (cis_mode) begin
          held_level.red   <= clip_diff(signal_sync.red, reference_sync.red);
          held_level.green <= clip_diff(signal_sync.green, reference_sync.green);
          held_level.blue  <= clip_diff(signal_sync.blue, reference_sync.blue);
        end else begin
          held_reference <= signal_sync;
        end
      end
      // A pixel clock edge is ignored in CIS mode since it should stay low.
      if (pix_fall && !cis_mode) begin
        held_level.red   <= clip_diff(held_reference.red, signal_sync.red);
        held_level.green <= clip_diff(held_reference.green, signal_sync.green);
        held_level.blue  <= clip_diff(held_reference.blue, signal_sync.blue);
      end
    end
  end

  // The synchronised strobe counts too, so the rise that starts a line is already converted.
  assign converting = (seq_state == scan_sampling_pkg::SEQ_RUN) |
                      pins_sync.line_start_strobe;

  // Once a line has started the sequencer runs until reset; later strobes only realign the mux.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      seq_state <= scan_sampling_pkg::SEQ_IDLE;
    end else begin
      unique case (seq_state)
        scan_sampling_pkg::SEQ_IDLE: begin
          if (conv_rise && pins_sync.line_start_strobe) begin
            seq_state <= scan_sampling_pkg::SEQ_RUN;
          end
        end
        scan_sampling_pkg::SEQ_RUN: begin
          seq_state <= scan_sampling_pkg::SEQ_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mux_channel <= scan_sampling_pkg::CH_RED;
    end else if (one_channel) begin
      mux_channel <= safe_channel(selected_channel);
    end else if (strobe_fall) begin
      // The strobe fall outranks an advance in the same cycle, so a line restarts cleanly.
      mux_channel <= first_channel(bgr_order);
    end else if (conv_rise && converting) begin
      mux_channel <= next_channel(mux_channel, bgr_order);
    end
  end

  // One converter serves all channels, one word per converter clock rise once a line has started.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      conv_data_o    <= '0;
      conv_channel_o <= '0;
    end else if (conv_rise && converting) begin
      conv_data_o    <= process_level(pick(held_level, mux_channel),
                                      offset_reg[mux_channel],
                                      gain_reg[mux_channel],
                                      full_scale_mv);
      conv_channel_o <= mux_channel;
    end
  end

  // The valid pulse lasts one cycle; data and channel hold until the next word.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      conv_valid_o <= 1'b0;
    end else begin
      conv_valid_o <= conv_rise & converting;
    end
  end

  // One-channel operation enables only the channel that feeds the converter.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      channel_enable_o <= 3'h0;
    end else if (!one_channel) begin
      channel_enable_o <= 3'h7;
    end else begin
      channel_enable_o <= 3'h1 << safe_channel(selected_channel);
    end
  end

  // Bias only makes sense for AC-coupled charge-coupled inputs, so CIS mode gates it off.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clamp_active_o <= 1'b0;
    end else begin
      clamp_active_o <= pins_sync.black_clamp_enable & ~cis_mode;
    end
  end

  // The level follows the reference choice bit even when an external reference is used.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clamp_level_mv_o <= scan_sampling_pkg::CLAMP_1V0_MV;
    end else begin
      clamp_level_mv_o <= config_reg[scan_sampling_pkg::REF_SELECT_BIT] ?
                          scan_sampling_pkg::CLAMP_1V5_MV :
                          scan_sampling_pkg::CLAMP_1V0_MV;
    end
  end

endmodule

`default_nettype wire

// >>> shared/scan_sampling_pkg.sv
package scan_sampling_pkg;

  localparam int SAMPLE_W = 12;
  localparam int OFFSET_W = 8;
  localparam int GAIN_W   = 5;
  localparam int ADDR_W   = 3;
  localparam int DATA_W   = 8;
  localparam int CFG_W    = 7;

  localparam logic [ADDR_W-1:0] ADDR_CONFIG       = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_RED_OFFSET   = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_GREEN_OFFSET = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_BLUE_OFFSET  = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_RED_GAIN     = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_GREEN_GAIN   = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_BLUE_GAIN    = 3'h6;

  localparam int SENSOR_TYPE_BIT     = 0;
  localparam int REF_SELECT_BIT      = 1;
  localparam int EXT_REF_BIT         = 2;
  localparam int CHANNEL_COUNT_BIT   = 3;
  localparam int CHANNEL_SELECT_LOW  = 4;
  localparam int CHANNEL_SELECT_HIGH = 5;
  localparam int MUX_ORDER_BIT       = 6;

  localparam logic [CFG_W-1:0]    CONFIG_RESET = 7'h00;
  localparam logic [OFFSET_W-1:0] OFFSET_RESET = 8'h00;
  localparam logic [GAIN_W-1:0]   GAIN_RESET   = 5'h00;

  // Gain is 4/(4 - 0.1X), computed as GAIN_NUM/(GAIN_NUM - X).
  localparam int GAIN_NUM = 40;

  // Offset span in millivolts: code 0 is the minimum, all ones the maximum.
  localparam int OFFSET_MIN_MV  = -150;
  localparam int OFFSET_SPAN_MV = 200;
  localparam int OFFSET_CODES   = 255;

  // Full-scale input is twice the reference voltage.
  localparam int FULL_SCALE_1V0_MV = 2000;
  localparam int FULL_SCALE_1V5_MV = 3000;
  localparam int SAMPLE_CODES      = 4096;
  localparam int SAMPLE_MAX        = 4095;

  localparam logic [11:0] CLAMP_1V0_MV = 12'h9C4;
  localparam logic [11:0] CLAMP_1V5_MV = 12'hBB8;

  typedef enum logic [1:0] {
    CH_RED   = 2'b00,
    CH_GREEN = 2'b01,
    CH_BLUE  = 2'b10,
    CH_RSVD  = 2'b11
  } channel_t;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_RUN  = 1'b1
  } seq_state_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] red;
    logic [SAMPLE_W-1:0] green;
    logic [SAMPLE_W-1:0] blue;
  } rgb_t;

  typedef struct packed {
    logic reference_sample_clock;
    logic pixel_sample_clock;
    logic converter_clock;
    logic line_start_strobe;
    logic black_clamp_enable;
  } timing_pins_t;

endpackage

// >>> verification/scan_timing_model.sv
`timescale 1ns/10ps
`default_nettype none

// Every clock of this generator idles low outside its pulses, except the reference sample clock that conv can raise and leave high;
// sample edges land while the converter clock is low.
module scan_timing_model (
  input  wire logic                            ref_clk_i,
  output var  scan_sampling_pkg::timing_pins_t pins_o
);
  initial pins_o = '0;

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic conv(input bit ref_up);
    pins_o.converter_clock <= 1'b1;
    tick(3);
    if (ref_up) pins_o.reference_sample_clock <= 1'b1;
    tick(3);
    pins_o.converter_clock <= 1'b0;
    tick(6);
  endtask

  task automatic ref_fall();
    pins_o.reference_sample_clock <= 1'b1;
    tick(6);
    pins_o.reference_sample_clock <= 1'b0;
    tick(6);
  endtask

  task automatic pix();
    pins_o.pixel_sample_clock <= 1'b1;
    tick(6);
    pins_o.pixel_sample_clock <= 1'b0;
    tick(6);
  endtask

  task automatic strobe(input bit v);
    pins_o.line_start_strobe <= v;
    tick(8);
  endtask

  task automatic clamp(input bit v);
    pins_o.black_clamp_enable <= v;
    tick(2);
  endtask
endmodule
`default_nettype wire

// >>> verification/scan_sampling_checker.sv
`timescale 1ns/10ps
`default_nettype none

module scan_sampling_checker (
  input wire logic                                 ref_clk_i,
  input wire logic                                 reset_n_i,
  input wire logic [scan_sampling_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [scan_sampling_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic                                 reg_wr_i,
  input wire logic                                 reg_rd_i,
  input wire logic [scan_sampling_pkg::DATA_W-1:0] reg_rdata_o,
  input wire scan_sampling_pkg::timing_pins_t      timing_pins_i,
  input wire logic                                 conv_valid_o,
  input wire logic [1:0]                           conv_channel_o,
  input wire logic [2:0]                           channel_enable_o,
  input wire logic                                 clamp_active_o,
  input wire logic [11:0]                          clamp_level_mv_o
);
  logic [6:0] cfg;
  logic [3:0] cfg_age;
  logic [1:0] last_ch;
  logic       have_last;
  logic       strobe_fell;
  logic [1:0] nxt;
  logic [1:0] first_ch;

  assign nxt = cfg[6] ? ((last_ch == 2'h0) ? 2'h2 : last_ch - 2'h1)
                      : ((last_ch == 2'h2) ? 2'h0 : last_ch + 2'h1);
  assign first_ch = cfg[6] ? 2'h2 : 2'h0;

  // The age counter lets registered outputs settle before they are judged.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg <= 7'h00;
      cfg_age <= 4'h0;
    end else if (reg_wr_i && reg_addr_i == scan_sampling_pkg::ADDR_CONFIG) begin
      cfg <= reg_wdata_i[6:0];
      cfg_age <= 4'h0;
    end else if (cfg_age != 4'hF) begin
      cfg_age <= cfg_age + 4'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_ch <= 2'h0;
      have_last <= 1'b0;
    end else if (reg_wr_i) begin
      have_last <= 1'b0;
    end else if (conv_valid_o) begin
      last_ch <= conv_channel_o;
      have_last <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) strobe_fell <= 1'b0;
    else if ($fell(timing_pins_i.line_start_strobe)) strobe_fell <= 1'b1;
    else if (conv_valid_o) strobe_fell <= 1'b0;
  end

  default clocking dc @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_CLAMP_LEVEL:
    assert property (cfg_age >= 4'h2 |-> clamp_level_mv_o == (cfg[1] ? 12'hBB8 : 12'h9C4))
    else $error("clamp level does not follow reference choice");
  AST_CHANNEL_ENABLE:
    assert property (cfg_age >= 4'h2 && !(cfg[3] && cfg[5:4] == 2'h3) |->
      channel_enable_o == (cfg[3] ? (3'b001 << cfg[5:4]) : 3'h7))
    else $error("channel enables do not match mode");
  AST_CLAMP_ACTIVE:
    assert property ((cfg_age >= 4'h4 && $stable(timing_pins_i.black_clamp_enable))[*5] |->
      clamp_active_o == (timing_pins_i.black_clamp_enable && !cfg[0]))
    else $error("clamp bias state wrong");
  AST_SINGLE_CHANNEL:
    assert property (conv_valid_o && cfg[3] && cfg[5:4] != 2'h3 && cfg_age == 4'hF |->
      conv_channel_o == cfg[5:4])
    else $error("single channel mode converted another channel");
  AST_MUX_ORDER:
    assert property (conv_valid_o && have_last && !strobe_fell && !cfg[3] |-> conv_channel_o == nxt)
    else $error("multiplexer stepped out of order");
  AST_STROBE_FIRST:
    assert property (conv_valid_o && strobe_fell && !cfg[3] |-> conv_channel_o == first_ch)
    else $error("line start did not return to first channel");
  AST_VALID_AFTER_RISE:
    assert property (conv_valid_o |->
      $past(timing_pins_i.converter_clock, 3) && !$past(timing_pins_i.converter_clock, 6))
    else $error("conversion without converter clock rise");
  AST_READ_DATA_IDLE:
    assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read answer cycle");
endmodule

bind scan_sampling_sequencer scan_sampling_checker chk (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .timing_pins_i(timing_pins_i), .conv_valid_o(conv_valid_o),
  .conv_channel_o(conv_channel_o), .channel_enable_o(channel_enable_o),
  .clamp_active_o(clamp_active_o), .clamp_level_mv_o(clamp_level_mv_o));
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  localparam int EXT_FS = 2400;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_pend = 1'b0;
  logic [7:0] rdata, d;
  logic [11:0] cdata;
  logic cvalid;
  logic [1:0] cchan;
  logic [2:0] cen;
  logic cact;
  logic [11:0] clvl;
  logic [11:0] sg[3] = '{12'h000, 12'h000, 12'h000};
  logic [11:0] rf[3] = '{12'h000, 12'h000, 12'h000};
  logic [6:0] cfg;
  logic [6:0] modes[7] = '{7'h00, 7'h40, 7'h01, 7'h18, 7'h29, 7'h0A, 7'h45};
  scan_sampling_pkg::timing_pins_t pins;
  int error_cnt = 0;
  int checked = 0;
  int ptr, fs;
  int lvl[3], off[3], gn[3];
  bit ccd;
  logic [7:0] rq[$];
  logic [13:0] cq[$];

  scan_sampling_sequencer #(.EXT_FULL_SCALE_MV(EXT_FS)) dut (
    .ref_clk_i(ref_clk), .reset_n_i(reset_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .timing_pins_i(pins),
    .signal_in_i({sg[0], sg[1], sg[2]}), .reference_in_i({rf[0], rf[1], rf[2]}),
    .conv_data_o(cdata), .conv_valid_o(cvalid), .conv_channel_o(cchan),
    .channel_enable_o(cen), .clamp_active_o(cact), .clamp_level_mv_o(clvl));
  scan_timing_model gen (.ref_clk_i(ref_clk), .pins_o(pins));

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic cmp_read(input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch read data expected %h seen %h", e, s);
    end
  endtask

  task automatic cmp_conv(input logic [13:0] e, input logic [13:0] s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch channel and sample expected %h seen %h", e, s);
    end
  endtask

  task automatic cmp_status(input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch enables clamp and level expected %h seen %h", e, s);
    end
  endtask

  task automatic write_reg(input logic [2:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic read_reg(input logic [2:0] a, input logic [7:0] e);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    rq.push_back(e);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Offset is applied ahead of the gain, so a negative sum clips before scaling.
  function automatic logic [11:0] calc(input int lv, input int oc, input int g);
    int v;
    v = lv + (-150 + oc * 200 / 255) * 4096 / fs;
    if (v < 0) v = 0;
    v = v * 40 / (40 - g);
    if (v > 4095) v = 4095;
    return v[11:0];
  endfunction

  // In both sensor kinds the level is the first sample minus the second, floored at zero.
  task automatic pixel();
    int a[3], b[3];
    for (int c = 0; c < 3; c++) begin
      a[c] = $urandom_range(4095);
      b[c] = $urandom_range(4095);
      sg[c] <= 12'(a[c]);
      rf[c] <= 12'(b[c]);
      lvl[c] = a[c] > b[c] ? a[c] - b[c] : 0;
    end
    gen.ref_fall();
    if (ccd) begin
      for (int c = 0; c < 3; c++) sg[c] <= 12'(b[c]);
      gen.pix();
    end
  endtask

  task automatic cv();
    logic [1:0] ch;
    ch = cfg[3] ? cfg[5:4] : (cfg[6] ? 2'(2 - ptr) : 2'(ptr));
    cq.push_back({ch, calc(lvl[ch], off[ch], gn[ch])});
    gen.conv(ccd && cfg[3]);
    ptr = (ptr + 1) % 3;
  endtask

  task automatic run_mode(input logic [6:0] c, input int m);
    logic [15:0] st;
    cfg = c;
    ccd = !c[0];
    fs = c[2] ? EXT_FS : (c[1] ? 3000 : 2000);
    write_reg(scan_sampling_pkg::ADDR_CONFIG, {1'b0, c});
    for (int k = 0; k < 3; k++) begin
      off[k] = (m == 1) ? 255 : $urandom_range(255);
      gn[k] = (m == 1) ? 31 : $urandom_range(31);
      write_reg(3'(scan_sampling_pkg::ADDR_RED_OFFSET + k), 8'(off[k]));
      write_reg(3'(scan_sampling_pkg::ADDR_RED_GAIN + k), 8'(gn[k]));
    end
    gen.clamp(m % 3 != 0);
    gen.strobe(1'b1);
    gen.strobe(1'b0);
    ptr = 0;
    gen.strobe(1'b1);
    pixel();
    cv();
    if (!c[3]) begin
      gen.strobe(1'b0);
      ptr = 0;
    end
    repeat (2) begin
      pixel();
      repeat (c[3] ? 1 : 3) cv();
    end
    gen.strobe(1'b0);
    st = {(c[3] ? 3'b001 << c[5:4] : 3'h7), (ccd && (m % 3 != 0)), (c[1] ? 12'hBB8 : 12'h9C4)};
    cmp_status(st, {cen, cact, clvl});
    $display("test mode %h done", c);
  endtask

  always @(posedge ref_clk) begin
    if (rd_pend) cmp_read(rq.pop_front(), rdata);
    rd_pend <= reg_rd;
    if (cvalid !== 1'b0) cmp_conv(cq.size() ? cq.pop_front() : 14'h3FFF, {cchan, cdata});
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    $display("mismatch run length expected finish seen timeout");
    finish_test();
  end

  initial begin
    void'($urandom(99081));
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    gen.conv(1'b0);
    for (int a = 0; a < 8; a++) read_reg(3'(a), 8'h00);
    for (int a = 0; a < 8; a++) begin
      d = 8'($urandom);
      write_reg(3'(a), d);
      read_reg(3'(a), a == 7 ? 8'h00 : (a == 0 ? {1'b0, d[6:0]} : (a > 3 ? {3'h0, d[4:0]} : d)));
    end
    $display("test registers done");
    for (int m = 0; m < 7; m++) run_mode(modes[m], m);
    checked++;
    if (cq.size() != 0) begin
      error_cnt++;
      $display("mismatch pending conversions expected 0 seen %0d", cq.size());
    end
    finish_test();
  end
endmodule
`default_nettype wire
